// [hw/batch_seq_cfg.svh]
// Constants for the batch sequencer: widths and timing counts
`ifndef BATCH_SEQ_CFG_SVH
`define BATCH_SEQ_CFG_SVH

`define QTY_W 24
`define TMR_W 14
`define TOUT_W 8
`define CLK_MHZ 250
`define TICK_US 1000000
`define TICK_CYC (`TICK_US * `CLK_MHZ)
`define TICK_CNT_W 28

`endif

// [hw/batch_seq_pkg.sv]
// Types shared by the batch sequencer
package batch_seq_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RUN = 4'h2,
        ST_DONE = 4'h4,
        ST_WAIT = 4'h8
    } seq_state_type;
endpackage : batch_seq_pkg

// [hw/batch_sequencer.sv]
// Batch sequencer: batch total, two-stage valve relays, restart and timeout
// What this block does
// - Entered batch quantity capped at maximum size; maximum zero means no limit.
// - Timed restart starts a new batch after programmed delay following batch end.
// - After start, wait slow-start delay, then energise relay 2.
// - Drop relay 2 when remaining quantity equals prestop quantity.
// - Batch total counts down from batch quantity or up from zero.
// - Flow signal timeout in seconds supervises flow; zero disables it.
// - Overrun compensation acts only when enabled and timeout is nonzero.
// - Auto-reset setting ignored while timed restart is on.
// - Without auto reset, run refused until total cleared by manual reset.
// - With auto reset, run key clears total and starts the batch.
`include "batch_seq_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module batch_sequencer
    import batch_seq_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic run_key,
    input wire logic stop_key,
    input wire logic reset_key,
    input wire logic [`QTY_W-1:0] batch_qty_in,
    input wire logic [`QTY_W-1:0] max_batch,
    input wire logic restart_en,
    input wire logic [`TMR_W-1:0] restart_secs,
    input wire logic [`TMR_W-1:0] slow_start_secs,
    input wire logic [`QTY_W-1:0] prestop_qty,
    input wire logic count_up,
    input wire logic [`TOUT_W-1:0] timeout_secs,
    input wire logic overrun_compensation,
    input wire logic auto_reset,
    input wire logic flow_pulse,
    output logic relay1,
    output logic relay2,
    output logic [`QTY_W-1:0] batch_total,
    output logic batch_active,
    output logic signal_timeout,
    output logic [`QTY_W-1:0] overrun_qty
);
    import batch_seq_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        seq_state_type st;
        logic [`QTY_W-1:0] qty;
        logic [`QTY_W-1:0] done;
        logic [`QTY_W-1:0] total;
        logic cleared;
        logic r1;
        logic r2;
        logic [`TICK_CNT_W-1:0] tick;
        logic [`TMR_W-1:0] secs;
        logic [`TOUT_W-1:0] idle_secs;
        logic tout;
        logic [`QTY_W-1:0] ovr;
        logic active;
    } seq_type;

    seq_type cur_ff;
    seq_type nxt_s;
    logic rst_meta_ff;
    logic rst_sync_ff;

    // Operator quantity limited to the programmed maximum size
    function automatic logic [`QTY_W-1:0] cap_qty(
        input logic [`QTY_W-1:0] q,
        input logic [`QTY_W-1:0] mx);
        logic [`QTY_W-1:0] r;
        r = q;
        if (mx != `QTY_W'h0 && q > mx)
            r = mx;
        return r;
    endfunction : cap_qty

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    logic comp_on;
    logic auto_rst_eff;
    logic sec_tick;
    logic [`QTY_W-1:0] target;
    logic [`QTY_W-1:0] remain;

    assign comp_on = overrun_compensation && (timeout_secs != `TOUT_W'h0);
    assign auto_rst_eff = auto_reset && !restart_en;
    assign sec_tick = (cur_ff.tick == `TICK_CNT_W'(`TICK_CYC - 1));
    assign target = (comp_on && cur_ff.ovr < cur_ff.qty) ?
        cur_ff.qty - cur_ff.ovr : cur_ff.qty;
    assign remain = (cur_ff.done < target) ? target - cur_ff.done
        : `QTY_W'h0;

    always_comb
    begin
        nxt_s = cur_ff;
        nxt_s.tick = sec_tick ? `TICK_CNT_W'h0 : cur_ff.tick + 1'b1;
        if (reset_key && cur_ff.st != ST_RUN)
        begin
            nxt_s.done = `QTY_W'h0;
            nxt_s.cleared = 1'b1;
        end
        unique case (cur_ff.st)
            ST_IDLE, ST_DONE, ST_WAIT:
            begin
                if (cur_ff.st == ST_WAIT && sec_tick)
                    nxt_s.secs = cur_ff.secs + 1'b1;
                if ((run_key && (cur_ff.cleared || auto_rst_eff))
                    || (cur_ff.st == ST_WAIT && cur_ff.secs >= restart_secs))
                begin
                    nxt_s.st = ST_RUN;
                    nxt_s.qty = cap_qty(batch_qty_in, max_batch);
                    nxt_s.done = `QTY_W'h0;
                    nxt_s.cleared = 1'b0;
                    nxt_s.r1 = 1'b1;
                    nxt_s.r2 = 1'b0;
                    nxt_s.secs = `TMR_W'h0;
                    nxt_s.idle_secs = `TOUT_W'h0;
                    nxt_s.tout = 1'b0;
                    nxt_s.tick = `TICK_CNT_W'h0;
                end
            end
            ST_RUN:
            begin
                if (flow_pulse)
                begin
                    nxt_s.done = cur_ff.done + 1'b1;
                    nxt_s.idle_secs = `TOUT_W'h0;
                end
                else if (sec_tick && cur_ff.idle_secs != `TOUT_W'hFF)
                    nxt_s.idle_secs = cur_ff.idle_secs + 1'b1;
                if (sec_tick && cur_ff.secs != {`TMR_W{1'b1}})
                    nxt_s.secs = cur_ff.secs + 1'b1;
                if (cur_ff.secs >= slow_start_secs && remain > prestop_qty)
                    nxt_s.r2 = 1'b1;
                if (remain <= prestop_qty)
                    nxt_s.r2 = 1'b0;
                if (timeout_secs != `TOUT_W'h0 && !flow_pulse
                    && cur_ff.idle_secs >= timeout_secs)
                begin
                    nxt_s.tout = 1'b1;
                    nxt_s.st = ST_DONE;
                    nxt_s.r1 = 1'b0;
                    nxt_s.r2 = 1'b0;
                end
                else if (stop_key)
                begin
                    nxt_s.st = ST_DONE;
                    nxt_s.r1 = 1'b0;
                    nxt_s.r2 = 1'b0;
                end
                else if (cur_ff.done >= target)
                begin
                    nxt_s.st = restart_en ? ST_WAIT : ST_DONE;
                    nxt_s.r1 = 1'b0;
                    nxt_s.r2 = 1'b0;
                    nxt_s.secs = `TMR_W'h0;
                    nxt_s.ovr = `QTY_W'h0;
                end
            end
            default:
                nxt_s.st = ST_IDLE;
        endcase
        // Flow arriving after a completed batch is the valve overrun.
        // A unit landing on the start cycle is dropped so the new total
        // still starts clean.
        if (cur_ff.st != ST_RUN && nxt_s.st != ST_RUN && flow_pulse)
        begin
            nxt_s.done = cur_ff.done + 1'b1;
            nxt_s.ovr = cur_ff.ovr + 1'b1;
        end
        nxt_s.total = count_up ? nxt_s.done :
            ((nxt_s.done < nxt_s.qty) ? nxt_s.qty - nxt_s.done : `QTY_W'h0);
        nxt_s.active = (nxt_s.st == ST_RUN);
    end

    always_ff @(posedge mclk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            cur_ff <= '0;
            cur_ff.st <= ST_IDLE;
            cur_ff.cleared <= 1'b1;
        end
        else
            cur_ff <= nxt_s;
    end

    assign relay1 = cur_ff.r1;
    assign relay2 = cur_ff.r2;
    assign batch_total = cur_ff.total;
    assign batch_active = cur_ff.active;
    assign signal_timeout = cur_ff.tout;
    assign overrun_qty = cur_ff.ovr;

    // ****************************************
    // Checks
    // ****************************************
    sequence relay_drop_s;
        cur_ff.st == ST_RUN && !stop_key && cur_ff.done >= target
            && !(timeout_secs != 0 && !flow_pulse
                 && cur_ff.idle_secs >= timeout_secs);
    endsequence

    relays_off_end_a: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        relay_drop_s |=> !relay1 && !relay2) else $error("relays on after end");
    r2_prestop_a: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        cur_ff.st == ST_RUN && remain <= prestop_qty |=> !relay2)
        else $error("relay2 on inside prestop");
    r2_slow_a: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        $rose(relay2) |-> $past(cur_ff.secs) >= slow_start_secs)
        else $error("relay2 before slow start");
    refuse_run_a: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        cur_ff.st == ST_DONE && run_key && !cur_ff.cleared && !auto_rst_eff
        |=> !batch_active) else $error("run not refused");
    auto_reset_a: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        cur_ff.st == ST_DONE && run_key && auto_reset && !restart_en
        |=> batch_active ##0 cur_ff.done == 0) else $error("auto reset");
    tout_off_a: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        timeout_secs == 0 |=> !$rose(signal_timeout))
        else $error("timeout while disabled");
    comp_gate_a: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        !comp_on |-> target == cur_ff.qty) else $error("compensation leak");
    cap_qty_a: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        $rose(batch_active) && $past(max_batch) != 0
        |-> cur_ff.qty <= $past(max_batch)) else $error("cap broken");
    restart_none_a: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        cur_ff.st == ST_DONE && !run_key |=> !batch_active)
        else $error("restart while disabled");
    count_dir_a: assert property (@(posedge mclk) disable iff (!rst_sync_ff)
        $rose(batch_active) |-> batch_total == (count_up ? 0 : cur_ff.qty))
        else $error("total start value");
endmodule : batch_sequencer

`default_nettype wire

// [sim/flow_meter.sv]
// Flow meter and two-stage valve partner for the batch sequencer bench
`timescale 1ns/100ps
`default_nettype none

module flow_meter
(
    input wire logic mclk,
    input wire logic relay1,
    input wire logic relay2,
    input wire logic [3:0] overrun_n,
    output var logic flow_pulse = 1'b0
);
    int cnt = 0;
    int tail = 0;
    logic r1_d = 1'b0;
    // Valve closes slowly: a few units still pass after relay 1 drops
    always @(posedge mclk)
    begin
        cnt <= cnt + 1;
        r1_d <= relay1;
        flow_pulse <= 1'b0;
        if (r1_d && !relay1)
            tail <= overrun_n;
        if (relay1 && cnt % (relay2 ? 4 : 8) == 0)
            flow_pulse <= 1'b1;
        else if (!relay1 && tail > 0 && cnt % 4 == 0)
        begin
            flow_pulse <= 1'b1;
            tail <= tail - 1;
        end
    end
endmodule : flow_meter
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the batch sequencer
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import batch_seq_pkg::*;
    logic mclk = 0, arst_n = 0, run_key = 0, stop_key = 0, reset_key = 0;
    logic restart_en = 0, count_up = 0, overrun_compensation = 0;
    logic auto_reset = 0, flow_pulse, relay1, relay2, batch_active;
    logic signal_timeout;
    logic [23:0] batch_qty_in = 0, max_batch = 0, prestop_qty = 1;
    logic [23:0] batch_total, overrun_qty;
    logic [13:0] restart_secs = 14'h3FFF, slow_start_secs = 14'h0000;
    logic [7:0] timeout_secs = 8'h00;
    logic [3:0] overrun_n = 4'h0;
    int err_count = 0, compares = 0, q, pre;

    always #2 mclk = ~mclk;

    batch_sequencer batch_sequencer_inst (.mclk(mclk), .arst_n(arst_n),
        .run_key(run_key), .stop_key(stop_key), .reset_key(reset_key),
        .batch_qty_in(batch_qty_in), .max_batch(max_batch),
        .restart_en(restart_en), .restart_secs(restart_secs),
        .slow_start_secs(slow_start_secs), .prestop_qty(prestop_qty),
        .count_up(count_up), .timeout_secs(timeout_secs),
        .overrun_compensation(overrun_compensation),
        .auto_reset(auto_reset), .flow_pulse(flow_pulse), .relay1(relay1),
        .relay2(relay2), .batch_total(batch_total),
        .batch_active(batch_active), .signal_timeout(signal_timeout),
        .overrun_qty(overrun_qty));

    flow_meter flow_meter_inst (.mclk(mclk), .relay1(relay1),
        .relay2(relay2), .overrun_n(overrun_n), .flow_pulse(flow_pulse));

    // ****************************************
    // Checking and stimulus tasks
    // ****************************************
    task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic results;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    task automatic press(ref logic k);
        k = 1'b1;
        @(negedge mclk);
        k = 1'b0;
    endtask : press

    task automatic batch(int qty, int pre, bit up);
        logic p2;
        int n;
        press(run_key);
        @(negedge mclk);
        chk("active", batch_active, 1);
        chk("start", batch_total, up ? 0 : qty);
        // Model: units seen on the meter line, counted a cycle ahead
        n = flow_pulse;
        @(negedge mclk);
        chk("relay2", relay2, 1);
        if (flow_pulse)
            n++;
        p2 = relay2;
        for (int i = 0; i < 4000; i++)
        begin
            @(negedge mclk);
            chk("total", batch_total, 24'(up ? n : qty - n));
            if (flow_pulse)
                n++;
            if (p2 && !relay2)
                chk("prestop", 24'(up ? qty - batch_total : batch_total), pre);
            p2 = relay2;
            if (!batch_active)
            begin
                chk("end", batch_total, up ? qty : 0);
                chk("relay1", relay1, 0);
                chk("timeout", signal_timeout, 0);
                return;
            end
        end
        err_count++;
        results();
    endtask : batch

    function automatic int capq(int q, int m);
        return (m != 0 && q > m) ? m : q;
    endfunction : capq

    initial
    begin
        void'($urandom(32'hDD9BAEDC));
        repeat (16) @(negedge mclk);
        arst_n = 1'b1;
        repeat (4) @(negedge mclk);
        for (int t = 0; t < 4; t++)
        begin
            q = 20 + $urandom % 30;
            pre = 1 + $urandom % 5;
            count_up = t[0];
            max_batch = t[1] ? 24'h00000F : 24'h000000;
            batch_qty_in = 24'(q);
            prestop_qty = 24'(pre);
            press(reset_key);
            batch(capq(q, max_batch), pre, t[0]);
            $display("test cap and direction %0d done", t);
        end
        press(run_key);
        repeat (3) @(negedge mclk);
        chk("refused", batch_active, 0);
        press(reset_key);
        @(negedge mclk);
        chk("cleared", batch_total, 0);
        $display("test manual reset done");
        auto_reset = 1'b1;
        overrun_n = 4'h3;
        batch(capq(q, max_batch), pre, 1'b1);
        $display("test auto reset done");
        restart_en = 1'b1;
        press(run_key);
        repeat (3) @(negedge mclk);
        chk("no_auto", batch_active, 0);
        $display("test auto reset lockout done");
        restart_en = 1'b0;
        overrun_compensation = 1'b1;
        // Let the valve tail settle so every late unit lands in the overrun
        repeat (16) @(negedge mclk);
        chk("overrun", overrun_qty, 3);
        batch(capq(q, max_batch), pre, 1'b1);
        repeat (16) @(negedge mclk);
        chk("overrun", overrun_qty, 3);
        timeout_secs = 8'h01;
        batch(capq(q, max_batch) - 3, pre, 1'b1);
        $display("test overrun done");
        repeat (16) @(negedge mclk);
        overrun_compensation = 1'b0;
        restart_secs = 14'h0000;
        press(reset_key);
        restart_en = 1'b1;
        batch(capq(q, max_batch), pre, 1'b1);
        @(negedge mclk);
        chk("restart", batch_active, 1);
        press(stop_key);
        chk("stopped", batch_active, 0);
        restart_en = 1'b0;
        $display("test timed restart done");
        results();
    end
endmodule : tb_top
`default_nettype wire
